// *** design/sbs_pkg.sv ***
// constants shared by both ends of the board synchronisation link
// assumes a 50 MHz system clock and an APB master on the board side
// Function
// - code 120 removes board from the group
// - group shares sample clock and trigger lines
// - shared bus joins four boards at most
// - exactly one clock master, others clock slaves
// - any joined board may be trigger master
// - clock-only sharing, boards trigger independently
// - hub joins sixteen boards, one link each
// - excluded board runs alone, others undisturbed
// - hub ORs triggers of several masters
// - OR combine only from hub revision four
// - code 101 trigger master, 111 trigger slave
// - trigger role needed before group start
// - no OR on bus; hub carrier must master
package sbs_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned LINK_CLK_PERIOD_NS = 160;
    localparam int unsigned LINK_HALF_CYC = LINK_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [3:0] LINK_HALF_LAST = 4'(LINK_HALF_CYC - 1);
    localparam logic [2:0] TRIG_HOLD_LAST = 3'h3;
    // register word offsets
    localparam logic [11:0] REG_BOARD_COMMAND = 12'h000;
    localparam logic [11:0] REG_SYNC_STATUS = 12'h004;
    // command codes
    localparam logic [31:0] CMD_EXCLUDE_FROM_GROUP = 32'h0000_0078;
    localparam logic [31:0] CMD_SET_TRIGGER_MASTER = 32'h0000_0065;
    localparam logic [31:0] CMD_SET_TRIGGER_SLAVE = 32'h0000_006F;
    localparam logic [31:0] CMD_SET_CLOCK_MASTER = 32'h0000_0082;
    localparam logic [31:0] CMD_SET_CLOCK_SLAVE = 32'h0000_0083;
    localparam logic [31:0] CMD_SET_CLOCK_ONLY = 32'h0000_0084;
    localparam logic [31:0] CMD_ARM = 32'h0000_0085;
    localparam logic [31:0] CMD_STOP = 32'h0000_0086;
    // status field positions
    localparam int unsigned ST_SYNC = 0;
    localparam int unsigned ST_CLK_MASTER = 1;
    localparam int unsigned ST_TRIG_MASTER = 2;
    localparam int unsigned ST_TRIG_SLAVE = 3;
    localparam int unsigned ST_CLOCK_ONLY = 4;
    localparam int unsigned ST_ARMED = 5;
    localparam int unsigned ST_RUNNING = 6;
    localparam int unsigned ST_CFG_ERROR = 7;
    // group limits
    localparam logic [4:0] CASCADE_MAX = 5'h04;
    localparam logic [4:0] HUB_MAX = 5'h10;
    localparam logic [3:0] HUB_OR_REV = 4'h4;
    localparam int unsigned PEERS = 15;
    typedef enum logic [1:0] {SBS_TR_NONE, SBS_TR_MASTER, SBS_TR_SLAVE} sbs_trig_role_e;
endpackage : sbs_pkg

// *** design/sbs_link_if.sv ***
// one board-to-group synchronisation link
// assumes the bench joins a board end and a hub end on one instance
`timescale 1ns/1ps
interface sbs_link_if;
    logic brd_clk;
    logic brd_clk_oe;
    logic brd_trig;
    logic brd_sync;
    logic brd_tmaster;
    logic hub_clk;
    logic hub_trig;
    modport board (output brd_clk, output brd_clk_oe, output brd_trig, output brd_sync,
        output brd_tmaster, input hub_clk, input hub_trig);
    modport hub (input brd_clk, input brd_clk_oe, input brd_trig, input brd_sync,
        input brd_tmaster, output hub_clk, output hub_trig);
endinterface : sbs_link_if

// *** design/sbs_board.sv ***
// board end: command and status registers over APB, role logic, sample timing
// assumes hub_clk and hub_trig arrive asynchronously from the group side
`timescale 1ns/1ps
module sbs_board import sbs_pkg::*; (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    sbs_link_if.board lnk,
    input wire logic i_local_trig,
    output logic o_sample_tick,
    output logic o_start,
    output logic o_running
);
    logic [31:0] board_command;
    logic sync_en;
    logic clk_master;
    logic clock_only;
    sbs_trig_role_e trig_role;
    logic armed;
    logic running;
    logic cfg_error;
    logic trig_req;
    logic [3:0] div_cnt;
    logic link_clk;
    logic local_tick;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] filt;
    logic [1:0] filt_q;
    logic hub_clk_rise;
    logic hub_trig_rise;
    logic acc;
    logic wr;
    logic mapped;
    logic cmd_wr;
    logic role_ok;
    logic start_now;

    assign acc = i_psel && i_penable;
    assign mapped = (i_paddr == REG_BOARD_COMMAND) || (i_paddr == REG_SYNC_STATUS);
    assign wr = acc && i_pwrite && mapped;
    assign cmd_wr = wr && (i_paddr == REG_BOARD_COMMAND);
    assign o_pready = 1'b1;
    assign o_pslverr = acc && !mapped;

    // three-stage input capture for hub clock and hub trigger
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    s1[g] <= 1'b0;
                    s2[g] <= 1'b0;
                    s3[g] <= 1'b0;
                    filt[g] <= 1'b0;
                    filt_q[g] <= 1'b0;
                end else begin
                    s1[g] <= (g == 0) ? lnk.hub_clk : lnk.hub_trig;
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g]) begin
                        filt[g] <= s3[g];
                    end
                    filt_q[g] <= filt[g];
                end
            end
        end
    endgenerate
    assign hub_clk_rise = filt[0] && !filt_q[0];
    assign hub_trig_rise = filt[1] && !filt_q[1];

    // command register and role state
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            board_command <= 32'h0000_0000;
            sync_en <= 1'b0;
            clk_master <= 1'b0;
            clock_only <= 1'b0;
            trig_role <= SBS_TR_NONE;
        end else if (cmd_wr) begin
            board_command <= i_pwdata;
            if (i_pwdata == CMD_EXCLUDE_FROM_GROUP) begin
                sync_en <= 1'b0;
                clk_master <= 1'b0;
                clock_only <= 1'b0;
                trig_role <= SBS_TR_NONE;
            end else if (i_pwdata == CMD_SET_TRIGGER_MASTER) begin
                sync_en <= 1'b1;
                clock_only <= 1'b0;
                trig_role <= SBS_TR_MASTER;
            end else if (i_pwdata == CMD_SET_TRIGGER_SLAVE) begin
                sync_en <= 1'b1;
                clock_only <= 1'b0;
                trig_role <= SBS_TR_SLAVE;
            end else if (i_pwdata == CMD_SET_CLOCK_MASTER) begin
                sync_en <= 1'b1;
                clk_master <= 1'b1;
            end else if (i_pwdata == CMD_SET_CLOCK_SLAVE) begin
                sync_en <= 1'b1;
                clk_master <= 1'b0;
            end else if (i_pwdata == CMD_SET_CLOCK_ONLY) begin
                sync_en <= 1'b1;
                clock_only <= 1'b1;
                trig_role <= SBS_TR_NONE;
            end
        end
    end

    // a joined board sharing the trigger must hold a trigger role to start
    assign role_ok = !sync_en || clock_only || (trig_role != SBS_TR_NONE);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cfg_error <= 1'b0;
        end else if (cmd_wr && i_pwdata == CMD_ARM) begin
            cfg_error <= !role_ok;
        end
    end

    // start: group trigger when sharing it, own trigger otherwise
    always_comb begin
        if (sync_en && !clock_only) begin
            start_now = armed && hub_trig_rise;
        end else begin
            start_now = armed && i_local_trig;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            armed <= 1'b0;
        end else if (start_now || (cmd_wr && i_pwdata == CMD_STOP)) begin
            armed <= 1'b0;
        end else if (cmd_wr && i_pwdata == CMD_ARM && role_ok && !running) begin
            armed <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            running <= 1'b0;
        end else if (start_now) begin
            running <= 1'b1;
        end else if (cmd_wr && i_pwdata == CMD_STOP) begin
            running <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_start <= 1'b0;
        end else begin
            o_start <= start_now;
        end
    end
    assign o_running = running;

    // trigger master holds its request until the group trigger comes back
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            trig_req <= 1'b0;
        end else if (!armed || !sync_en || clock_only || trig_role != SBS_TR_MASTER) begin
            trig_req <= 1'b0;
        end else if (i_local_trig) begin
            trig_req <= 1'b1;
        end
    end

    // local timebase, also the link clock when this board is clock master
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div_cnt <= 4'h0;
            link_clk <= 1'b0;
        end else if (div_cnt == LINK_HALF_LAST) begin
            div_cnt <= 4'h0;
            link_clk <= !link_clk;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end
    assign local_tick = (div_cnt == LINK_HALF_LAST) && !link_clk;

    // clock slaves follow the distributed clock while joined
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_sample_tick <= 1'b0;
        end else if (sync_en && !clk_master) begin
            o_sample_tick <= hub_clk_rise;
        end else begin
            o_sample_tick <= local_tick;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lnk.brd_clk <= 1'b0;
            lnk.brd_clk_oe <= 1'b0;
            lnk.brd_trig <= 1'b0;
            lnk.brd_sync <= 1'b0;
            lnk.brd_tmaster <= 1'b0;
        end else begin
            lnk.brd_clk <= link_clk && sync_en && clk_master;
            lnk.brd_clk_oe <= sync_en && clk_master;
            lnk.brd_trig <= trig_req;
            lnk.brd_sync <= sync_en;
            lnk.brd_tmaster <= sync_en && !clock_only && trig_role == SBS_TR_MASTER;
        end
    end

    // read data is captured in the setup cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            o_prdata <= 32'h0000_0000;
            if (i_paddr == REG_BOARD_COMMAND) begin
                o_prdata <= board_command;
            end else if (i_paddr == REG_SYNC_STATUS) begin
                o_prdata[ST_SYNC] <= sync_en;
                o_prdata[ST_CLK_MASTER] <= clk_master;
                o_prdata[ST_TRIG_MASTER] <= trig_role == SBS_TR_MASTER;
                o_prdata[ST_TRIG_SLAVE] <= trig_role == SBS_TR_SLAVE;
                o_prdata[ST_CLOCK_ONLY] <= clock_only;
                o_prdata[ST_ARMED] <= armed;
                o_prdata[ST_RUNNING] <= running;
                o_prdata[ST_CFG_ERROR] <= cfg_error;
            end
        end
    end
endmodule : sbs_board

// *** design/sbs_hub.sv ***
// group end: hub or shared bus joining this board's link with up to fifteen peers
// assumes peer role levels come from logic on the same clock
`timescale 1ns/1ps
module sbs_hub import sbs_pkg::*; #(
    parameter logic [3:0] HUB_REV = 4'h4
) (
    input wire logic i_clk,
    input wire logic i_srst,
    sbs_link_if.hub lnk,
    input wire logic i_cascade,
    input wire logic [3:0] i_carrier_sel,
    input wire logic [PEERS-1:0] i_peer_sync,
    input wire logic [PEERS-1:0] i_peer_clk_master,
    input wire logic [PEERS-1:0] i_peer_tmaster,
    input wire logic [PEERS-1:0] i_peer_trig,
    output logic o_group_trig,
    output logic o_or_allowed,
    output logic o_size_error,
    output logic o_clk_error,
    output logic o_trig_error
);
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
    logic [15:0] sync_v;
    logic [15:0] cm_v;
    logic [15:0] tm_v;
    logic [15:0] tr_v;
    logic [4:0] n_sync;
    logic [4:0] n_cm;
    logic [4:0] n_tm;
    logic fire;
    logic fire_q;
    logic [2:0] hold;
    logic [3:0] div_cnt;
    logic peer_clk;

    function automatic logic [4:0] count16(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++) begin
            n = n + 5'(v[i]);
        end
        return n;
    endfunction : count16

    // link inputs: 0 clock, 1 clock drive, 2 trigger, 3 joined
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    s1[g] <= 1'b0;
                    s2[g] <= 1'b0;
                    s3[g] <= 1'b0;
                    filt[g] <= 1'b0;
                end else begin
                    s1[g] <= (g == 0) ? lnk.brd_clk : (g == 1) ? lnk.brd_clk_oe :
                        (g == 2) ? lnk.brd_trig : lnk.brd_sync;
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g]) begin
                        filt[g] <= s3[g];
                    end
                end
            end
        end
    endgenerate

    assign sync_v = {i_peer_sync, filt[3]};
    assign cm_v = {i_peer_clk_master & i_peer_sync, filt[1] & filt[3]};
    assign tm_v = {i_peer_tmaster & i_peer_sync, lnk.brd_tmaster & filt[3]};
    assign tr_v = {i_peer_trig, filt[2]};
    assign n_sync = count16(sync_v);
    assign n_cm = count16(cm_v);
    assign n_tm = count16(tm_v);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_size_error <= 1'b0;
            o_clk_error <= 1'b0;
            o_or_allowed <= 1'b0;
            o_trig_error <= 1'b0;
        end else begin
            o_size_error <= n_sync > (i_cascade ? CASCADE_MAX : HUB_MAX);
            o_clk_error <= (n_sync != 5'h00) && (n_cm != 5'h01);
            o_or_allowed <= !i_cascade && (HUB_REV >= HUB_OR_REV)
                && tm_v[i_carrier_sel];
            o_trig_error <= (n_tm > 5'h01) && !o_or_allowed;
        end
    end

    // one master passes straight, several are ORed when allowed
    assign fire = !o_size_error && |(tm_v & tr_v)
        && ((n_tm == 5'h01) || (n_tm > 5'h01 && o_or_allowed));

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fire_q <= 1'b0;
            o_group_trig <= 1'b0;
        end else begin
            fire_q <= fire;
            o_group_trig <= fire && !fire_q;
        end
    end

    // stretch the group trigger so the board's capture sees it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hold <= 3'h0;
        end else if (fire && !fire_q) begin
            hold <= TRIG_HOLD_LAST;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end

    // stand-in clock for a peer that is clock master
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div_cnt <= 4'h0;
            peer_clk <= 1'b0;
        end else if (div_cnt == LINK_HALF_LAST) begin
            div_cnt <= 4'h0;
            peer_clk <= !peer_clk;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // an excluded board gets neither clock nor trigger
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lnk.hub_clk <= 1'b0;
            lnk.hub_trig <= 1'b0;
        end else begin
            lnk.hub_clk <= filt[3] && (filt[1] ? filt[0] : (|cm_v[15:1] && peer_clk));
            lnk.hub_trig <= filt[3] && ((fire && !fire_q) || hold != 3'h0);
        end
    end
endmodule : sbs_hub

// *** verif/sbs_link_properties.sv ***
// checker on the board-hub link signals
// assumes every link signal lives in the i_clk domain
`timescale 1ns/1ps
module sbs_link_properties (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic brd_clk,
    input wire logic brd_clk_oe,
    input wire logic brd_trig,
    input wire logic brd_sync,
    input wire logic brd_tmaster,
    input wire logic hub_clk,
    input wire logic hub_trig
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    oe_needs_join_a: assert property (brd_clk_oe |-> brd_sync)
        else $error("clock driven while not joined");
    clk_quiet_a: assert property (!brd_clk_oe |-> !brd_clk)
        else $error("clock active without drive");
    tmaster_join_a: assert property (brd_tmaster |-> brd_sync)
        else $error("trigger master while not joined");
    trig_from_master_a: assert property ($rose(brd_trig) |-> brd_tmaster)
        else $error("trigger request from non master");
    clk_half_period_a: assert property (($rose(brd_clk) && $past(brd_clk_oe))
        ##0 brd_clk_oe [*5] |-> !brd_clk && $past(brd_clk, 1) && $past(brd_clk, 3))
        else $error("link clock half period wrong");
    group_trig_len_a: assert property ($rose(hub_trig) |-> hub_trig [*4] ##1 !hub_trig)
        else $error("group trigger length wrong");
    hub_clk_cut_a: assert property ((!brd_sync) [*6] |-> !hub_clk)
        else $error("clock reaches excluded board");
    clk_echo_a: assert property ($rose(brd_clk)
        |-> ##[1:6] ($rose(hub_clk) || !brd_clk_oe))
        else $error("master clock not distributed");
    cover property ($rose(hub_trig));
    cover property ($rose(brd_clk));
    cover property ($fell(brd_sync));
endmodule : sbs_link_properties

// *** verif/multi_board_sync_control_tb.sv ***
// bench joining one board end to a hub end over one link and to an older hub end over a copy of that link
// assumes a 50 MHz clock and peer roles driven as plain levels
`timescale 1ns/1ps
module multi_board_sync_control_tb;
    import sbs_pkg::*;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic prdy, perr, tick, start, run, gtrig, orok, szerr, ckerr, tgerr;
    logic ltrig = 1'b0;
    logic cas = 1'b0;
    logic [3:0] csel = 4'h0;
    logic [PEERS-1:0] psync = '0;
    logic [PEERS-1:0] pcm = '0;
    logic [PEERS-1:0] ptm = '0;
    logic [PEERS-1:0] ptrg = '0;
    logic [31:0] rd, c, v;
    logic gtrig_old, orok_old, tgerr_old;
    logic er;
    int n_mismatch = 0;
    int comparisons = 0;
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    sbs_link_if sbs_link_if_i ();
    sbs_board sbs_board_i (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(prdy), .o_pslverr(perr), .lnk(sbs_link_if_i), .i_local_trig(ltrig),
        .o_sample_tick(tick), .o_start(start), .o_running(run));
    sbs_hub #(.HUB_REV(4'h4)) sbs_hub_i (.i_clk(i_clk), .i_srst(i_srst),
        .lnk(sbs_link_if_i), .i_cascade(cas), .i_carrier_sel(csel), .i_peer_sync(psync),
        .i_peer_clk_master(pcm), .i_peer_tmaster(ptm), .i_peer_trig(ptrg),
        .o_group_trig(gtrig), .o_or_allowed(orok), .o_size_error(szerr),
        .o_clk_error(ckerr), .o_trig_error(tgerr));
    sbs_link_if sbs_link_if_old_i ();
    assign sbs_link_if_old_i.brd_clk = sbs_link_if_i.brd_clk;
    assign sbs_link_if_old_i.brd_clk_oe = sbs_link_if_i.brd_clk_oe;
    assign sbs_link_if_old_i.brd_trig = sbs_link_if_i.brd_trig;
    assign sbs_link_if_old_i.brd_sync = sbs_link_if_i.brd_sync;
    assign sbs_link_if_old_i.brd_tmaster = sbs_link_if_i.brd_tmaster;
    // older hub revision on a copy of the same link, single master only
    sbs_hub #(.HUB_REV(4'h3)) sbs_hub_old_i (.i_clk(i_clk), .i_srst(i_srst),
        .lnk(sbs_link_if_old_i), .i_cascade(cas), .i_carrier_sel(csel), .i_peer_sync(psync),
        .i_peer_clk_master(pcm), .i_peer_tmaster(ptm), .i_peer_trig(ptrg),
        .o_group_trig(gtrig_old), .o_or_allowed(orok_old), .o_size_error(),
        .o_clk_error(), .o_trig_error(tgerr_old));
    sbs_link_properties sbs_link_properties_i (.i_clk(i_clk), .i_srst(i_srst),
        .brd_clk(sbs_link_if_i.brd_clk), .brd_clk_oe(sbs_link_if_i.brd_clk_oe),
        .brd_trig(sbs_link_if_i.brd_trig), .brd_sync(sbs_link_if_i.brd_sync),
        .brd_tmaster(sbs_link_if_i.brd_tmaster), .hub_clk(sbs_link_if_i.hub_clk),
        .hub_trig(sbs_link_if_i.hub_trig));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (prdy !== 1'b1 && k < 20);
        if (prdy !== 1'b1) begin
            $display("[ERR] pready exp 1 got %b", prdy);
            n_mismatch++;
            print_verdict();
        end
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_clk);
    endtask : apb
    task automatic wr(input logic [31:0] d);
        apb(1'b1, REG_BOARD_COMMAND, d);
    endtask : wr
    task automatic rdst(input int b, input logic e);
        apb(1'b0, REG_SYNC_STATUS, 32'h0);
        chk("status bit", 32'(e), 32'(rd[b]));
    endtask : rdst
    function automatic logic pick(input int s);
        case (s)
            0: return start;
            1: return gtrig;
            default: return tick;
        endcase
    endfunction : pick
    task automatic cnt(input int s, input int n);
        c = 32'h0;
        repeat (n) begin
            @(posedge i_clk);
            c += 32'(pick(s) === 1'b1);
        end
    endtask : cnt
    task automatic wait_on(input string nm, input int s, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(posedge i_clk);
            if (pick(s) === 1'b1) break;
        end
        comparisons++;
        if (k >= lim) begin
            $display("[ERR] %s exp 1 got 0", nm);
            n_mismatch++;
            print_verdict();
        end
    endtask : wait_on
    task automatic pulse_local();
        ltrig <= 1'b1;
        @(posedge i_clk);
        ltrig <= 1'b0;
    endtask : pulse_local
    initial begin
        void'($urandom(96));
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        rdst(ST_SYNC, 1'b0);
        for (int i = 0; i < 6; i++) begin
            v = $urandom() | 32'h0100_0000;
            wr(v);
            apb(1'b0, REG_BOARD_COMMAND, 32'h0);
            chk("command reg", v, rd);
        end
        apb(1'b1, REG_SYNC_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, REG_SYNC_STATUS, 32'h0);
        chk("status ro", 32'h0, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("pslverr", 32'h1, 32'(er));
        cnt(2, 64);
        chk("own ticks", 32'(64 / (2 * LINK_HALF_CYC)), c);
        $display("test registers done");
        wr(CMD_SET_CLOCK_MASTER);
        rdst(ST_CLK_MASTER, 1'b1);
        rdst(ST_SYNC, 1'b1);
        psync[0] <= 1'b1;
        pcm[0] <= 1'b1;
        repeat (10) @(posedge i_clk);
        chk("clk error", 32'h1, 32'(ckerr));
        pcm[0] <= 1'b0;
        repeat (10) @(posedge i_clk);
        chk("clk error", 32'h0, 32'(ckerr));
        $display("test clock master done");
        wr(CMD_ARM);
        rdst(ST_CFG_ERROR, 1'b1);
        rdst(ST_ARMED, 1'b0);
        wr(CMD_SET_TRIGGER_MASTER);
        rdst(ST_TRIG_MASTER, 1'b1);
        wr(CMD_ARM);
        rdst(ST_ARMED, 1'b1);
        pulse_local();
        wait_on("group trig", 1, 30);
        chk("old single trig", 32'h1, 32'(gtrig_old));
        wait_on("start", 0, 30);
        chk("running", 32'h1, 32'(run));
        wr(CMD_STOP);
        $display("test group start done");
        ptm[0] <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            cas <= (i == 3);
            csel <= 4'(i);
            repeat (8) @(posedge i_clk);
            chk("or allowed", 32'(i < 2), 32'(orok));
            chk("or allowed old", 32'h0, 32'(orok_old));
        end
        ptrg[0] <= 1'b1;
        cnt(1, 20);
        ptrg[0] <= 1'b0;
        chk("no trig", 32'h0, c);
        chk("trig error", 32'h1, 32'(tgerr));
        cas <= 1'b0;
        csel <= 4'h0;
        repeat (8) @(posedge i_clk);
        ptrg[0] <= 1'b1;
        wait_on("or trig", 1, 30);
        chk("old trig error", 32'h1, 32'(tgerr_old));
        ptrg[0] <= 1'b0;
        $display("test or trigger done");
        ptm[0] <= 1'b0;
        cas <= 1'b1;
        for (int n = 3; n <= 4; n++) begin
            psync <= 15'((1 << n) - 1);
            repeat (8) @(posedge i_clk);
            chk("size cascade", 32'(n + 1 > CASCADE_MAX), 32'(szerr));
        end
        cas <= 1'b0;
        psync <= '1;
        repeat (8) @(posedge i_clk);
        chk("size hub", 32'h0, 32'(szerr));
        $display("test group size done");
        psync <= 15'h1;
        pcm[0] <= 1'b1;
        wr(CMD_SET_CLOCK_SLAVE);
        rdst(ST_CLK_MASTER, 1'b0);
        repeat (16) @(posedge i_clk);
        cnt(2, 64);
        chk("slave ticks", 32'(64 / (2 * LINK_HALF_CYC)), c);
        wr(CMD_EXCLUDE_FROM_GROUP);
        rdst(ST_SYNC, 1'b0);
        repeat (8) @(posedge i_clk);
        chk("link joined", 32'h0, 32'(sbs_link_if_i.brd_sync));
        $display("test exclude done");
        wr(CMD_SET_CLOCK_ONLY);
        rdst(ST_CLOCK_ONLY, 1'b1);
        chk("no tmaster", 32'h0, 32'(sbs_link_if_i.brd_tmaster));
        wr(CMD_ARM);
        pulse_local();
        wait_on("own start", 0, 10);
        $display("test clock only done");
        wr(CMD_STOP);
        wr(CMD_SET_TRIGGER_SLAVE);
        rdst(ST_TRIG_SLAVE, 1'b1);
        wr(CMD_ARM);
        rdst(ST_ARMED, 1'b1);
        ptm[0] <= 1'b1;
        ptrg[0] <= 1'b1;
        wait_on("slave start", 0, 40);
        ptrg[0] <= 1'b0;
        $display("test trigger slave done");
        print_verdict();
    end
endmodule : multi_board_sync_control_tb
